// ### nbx_host.sv
// Host controller for a nibble bus port expander: one transfer per request.
// Assumes requests come from logic on i_core_clk; bus pins are asynchronous.
//
// Summary of operation
// - Transfers use only the nibble bus, timed by the host strobe pulse.
// - Each transfer is two nibbles: opcode with port, then data.
// - Host presents opcode and port at the strobe falling edge.
// - Host presents write data at the strobe rising edge.
// - Shared bus; one select low at a time, but a transfer's first select cycle uses the previous device.
// - Low bits pick port 0..3; high bits pick read, write, OR, AND.
// - Each expander instruction completes one strobe pulse transfer.
// - Host flags the first read after a write to that port as stale.
`timescale 1ns/1ns
module nbx_host
  import nbx_pkg::*;
#(
  parameter int NUM_DEV = 2
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire nbx_req_t i_req,
  input wire logic [$clog2(NUM_DEV > 1 ? NUM_DEV : 2)-1:0] i_req_dev,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [NIB_W-1:0] o_rsp_data,
  output logic o_rsp_stale,
  input wire logic [NIB_W-1:0] i_nib_in,
  output logic [NIB_W-1:0] o_nib_out,
  output logic o_nib_oe,
  output logic o_strobe,
  output logic [NUM_DEV-1:0] o_sel_n
);
  localparam int DW = $clog2(NUM_DEV > 1 ? NUM_DEV : 2);
  // Reads must honour the minimum strobe low width too, not only the access time
  localparam int WRITE_REST_CYC = STROBE_LOW_CYC - CODE_HOLD_CYC;
  localparam int READ_REST_CYC = (READ_ACCESS_CYC > WRITE_REST_CYC) ? READ_ACCESS_CYC : WRITE_REST_CYC;
  // Select decode and stale table are sized for at most sixteen expanders
  if (NUM_DEV < 1 || NUM_DEV > 16) begin : g_bad_num_dev
    $error("nbx_host: NUM_DEV out of range");
  end
  // Phase counts must fit the eight-bit delay counter
  if (READ_REST_CYC > 255 || WRITE_REST_CYC > 255) begin : g_bad_rest
    $error("nbx_host: strobe low phase too long for counter");
  end

  typedef enum logic [2:0] {S_IDLE, S_SEL, S_CODE, S_LOW, S_DATA, S_HOLD} nbx_state_t;
  nbx_state_t state_q, state_d;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  nbx_req_t req_q;
  logic [DW-1:0] dev_q;
  logic [NIB_W-1:0] nib_sync1_q, nib_sync2_q;
  logic [NIB_W-1:0] rsp_data_q;
  logic rsp_valid_q, rsp_stale_q;
  logic strobe_q, oe_q;
  logic [NIB_W-1:0] nib_out_q;
  logic [NUM_DEV-1:0] sel_n_q;
  // Per device, per port: last access was a write, so next read is stale
  logic [NUM_DEV*4-1:0] wrote_q;
  logic ld;
  logic [7:0] ld_cnt;
  logic tdone;
  logic [8:0] low_cnt_q;

  nbx_delay #(.W(8)) u_delay (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_load(ld),
    .i_count(ld_cnt),
    .o_done(tdone)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire is_read = (req_q.op == OP_READ);
  wire [DW+1:0] wr_idx = {dev_q, req_q.port};
  wire accept = (state_q == S_IDLE) && i_req_valid;
  assign o_req_ready = (state_q == S_IDLE);
  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_data = rsp_data_q;
  assign o_rsp_stale = rsp_stale_q;
  assign o_nib_out = nib_out_q;
  assign o_nib_oe = oe_q;
  assign o_strobe = strobe_q;
  assign o_sel_n = sel_n_q;

  // Sequencer: select, code setup, strobe low, data phase, hold
  always_comb begin
    state_d = state_q;
    ld = 1'b0;
    ld_cnt = 8'h00;
    case (state_q)
      S_IDLE: begin
        if (i_req_valid) begin
          state_d = S_SEL;
          ld = 1'b1;
          ld_cnt = 8'(SEL_SETUP_CYC);
        end
      end
      S_SEL: begin
        if (tdone) begin
          state_d = S_CODE;
          ld = 1'b1;
          ld_cnt = 8'(CODE_SETUP_CYC);
        end
      end
      S_CODE: begin
        if (tdone) begin
          state_d = S_LOW;
          ld = 1'b1;
          ld_cnt = 8'(CODE_HOLD_CYC);
        end
      end
      S_LOW: begin
        if (tdone) begin
          state_d = S_DATA;
          ld = 1'b1;
          // Read waits for access time or rest of low width; write waits out the rest of the strobe low width
          ld_cnt = is_read ? 8'(READ_REST_CYC) : 8'(WRITE_REST_CYC);
        end
      end
      S_DATA: begin
        if (tdone) begin
          state_d = S_HOLD;
          ld = 1'b1;
          ld_cnt = 8'(DATA_HOLD_CYC + SEL_SETUP_CYC);
        end
      end
      S_HOLD: begin
        if (tdone) begin
          state_d = S_IDLE;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // Two-flop sync on the returning nibble
  always_ff @(posedge i_core_clk) begin
    nib_sync1_q <= i_nib_in;
    nib_sync2_q <= nib_sync1_q;
  end

  // State and request capture
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q <= S_IDLE;
      req_q <= '0;
      dev_q <= '0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        req_q <= i_req;
        dev_q <= i_req_dev;
      end
    end
  end

  // Pin drive: strobe idles high, one select low at a time, from the previous dev_q in the first cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      strobe_q <= 1'b1;
      oe_q <= 1'b0;
      nib_out_q <= '0;
      sel_n_q <= '1;
    end else begin
      sel_n_q <= '1;
      if (state_d != S_IDLE) begin
        sel_n_q[dev_q] <= 1'b0;
      end
      strobe_q <= !(state_d == S_LOW || state_d == S_DATA);
      case (state_d)
        S_CODE, S_LOW: begin
          oe_q <= 1'b1;
          nib_out_q <= {req_q.op, req_q.port};
        end
        S_DATA: begin
          oe_q <= !is_read;
          nib_out_q <= req_q.data;
        end
        S_HOLD: begin
          oe_q <= !is_read;
        end
        default: begin
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Read result sampled just before the rising strobe edge
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
      rsp_stale_q <= 1'b0;
      wrote_q <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (state_q == S_DATA && tdone) begin
        if (is_read) begin
          rsp_valid_q <= 1'b1;
          rsp_data_q <= nib_sync2_q;
          rsp_stale_q <= wrote_q[wr_idx];
          wrote_q[wr_idx] <= 1'b0;
        end else begin
          wrote_q[wr_idx] <= 1'b1;
        end
      end
    end
  end

  // Strobe low width counter, saturating; only the width check reads it
  always_ff @(posedge i_core_clk) begin
    if (i_reset || strobe_q) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != 9'h1ff) begin
      low_cnt_q <= low_cnt_q + 9'h001;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  strobe_width_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(o_strobe) |-> low_cnt_q >= 9'(STROBE_LOW_CYC)) else $error("strobe low width below minimum");
  strobe_low_len_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(o_strobe) |-> !o_strobe [*8]) else $error("strobe low too short");
  code_on_fall_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(o_strobe) |-> o_nib_oe && o_nib_out == {req_q.op, req_q.port}) else $error("code not driven");
  data_on_rise_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(o_strobe) && !is_read |-> o_nib_oe && o_nib_out == req_q.data) else $error("data not driven");
  read_float_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(o_strobe) && is_read |-> !o_nib_oe) else $error("bus driven on read");
  one_select_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $onehot0(~o_sel_n) && (o_strobe || $onehot(~o_sel_n))) else $error("select not exclusive");
  one_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(o_strobe) |-> o_strobe [*2]) else $error("strobe glitch");
endmodule

// ### nbx_pkg.sv
// Package for the nibble bus expander host controller.
// Assumes one core clock domain; expander pins are asynchronous to it.
package nbx_pkg;
  // ----------------------------------------
  // Opcode and port field layout
  // ----------------------------------------
  localparam int NIB_W = 4;
  localparam int PORT_LSB = 0;
  localparam int OP_LSB = 2;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_OR = 2'h2;
  localparam logic [1:0] OP_AND = 2'h3;
  localparam int CORE_PERIOD_NS = 4;
  // ----------------------------------------
  // Strobe timing, figures in ns and in core clock cycles
  // ----------------------------------------
  localparam int CODE_SETUP_NS = 100;
  localparam int CODE_HOLD_NS = 60;
  localparam int DATA_SETUP_NS = 200;
  localparam int DATA_HOLD_NS = 20;
  localparam int STROBE_LOW_NS = 900;
  localparam int READ_ACCESS_NS = 750;
  localparam int SEL_SETUP_NS = 50;
  localparam int CODE_SETUP_CYC = (CODE_SETUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int CODE_HOLD_CYC = (CODE_HOLD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int DATA_SETUP_CYC = (DATA_SETUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int DATA_HOLD_CYC = (DATA_HOLD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  // Extra margin covers the two-flop input synchroniser
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS + 3;
  localparam int SEL_SETUP_CYC = (SEL_SETUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int STATE_RESET_SEL = 0;

  // Request carried from user to controller
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] port;
    logic [NIB_W-1:0] data;
  } nbx_req_t;
endpackage

// ### nbx_delay.sv
// Down counter used for every phase of the strobe sequence.
// Assumes a load pulse starts a count; o_done is high while zero.
`timescale 1ns/1ns
module nbx_delay
  import nbx_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  // Phase counts of the strobe sequence need at least eight bits
  if (W < 8) begin : g_bad_w
    $error("nbx_delay: counter too narrow");
  end
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  assign cnt_d = i_load ? i_count : (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
  assign o_done = (cnt_q == '0);

  // Load wins over counting
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ### nbx_exp_model.sv
// Behavioural expander device: four 4-bit ports behind a nibble bus.
// Assumes a host drives strobe, select and nibble; clockless, edge driven.
`timescale 1ns/1ns
module nbx_exp_model
  import nbx_pkg::*;
(
  input wire logic i_strobe,
  input wire logic i_sel_n,
  input wire logic [3:0] i_nib,
  input wire logic [15:0] i_ext,
  output logic [3:0] o_nib,
  output logic o_nib_oe,
  output logic [15:0] o_port,
  output logic [3:0] o_port_oe
);
  logic [1:0] op_q;
  logic [1:0] port_q;
  logic [3:0] v;
  // Power on: ports float, bus listens, strobe level irrelevant
  initial begin
    o_nib_oe = 1'b0;
    o_port_oe = 4'h0;
    o_port = 16'h0;
    o_nib = 4'h0;
    op_q = OP_WRITE;
    port_q = 2'h0;
  end
  // Falling edge: capture code nibble, start a read
  always @(negedge i_strobe) begin
    if (!i_sel_n) begin
      op_q = i_nib[3:2];
      port_q = i_nib[1:0];
      if (op_q == OP_READ) begin
        o_port_oe[port_q] = 1'b0;
        o_nib = i_ext[port_q*4+:4];
        o_nib_oe = 1'b1;
      end
    end
  end
  // Rising edge: release bus or merge data into own latch and drive that port
  always @(posedge i_strobe) begin
    if (!i_sel_n) begin
      v = o_port[port_q*4+:4];
      case (op_q)
        OP_READ: o_nib_oe = 1'b0;
        OP_WRITE: v = i_nib;
        OP_OR: v = v | i_nib;
        default: v = v & i_nib;
      endcase
      if (op_q != OP_READ) begin
        o_port[port_q*4+:4] = v;
        o_port_oe[port_q] = 1'b1;
      end
    end
  end
endmodule

// ### testbench.sv
// Self-checking bench: host controller driving two expander models.
// Assumes the models share one nibble bus with no pull resistor.
`timescale 1ns/1ns
module testbench;
  import nbx_pkg::*;
  // ----
  // Wiring
  // ----
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  nbx_req_t req = '0;
  logic req_dev = 1'b0;
  logic ready, rsp_valid, rsp_stale, h_oe, strobe, st, got;
  logic [3:0] rsp_data, h_out, n0, n1, poe0, poe1, rd;
  logic [3:0] last = 4'h0;
  logic [3:0] lat [4];
  logic [1:0] sel_n;
  wire [1:0] d_oe;
  logic [15:0] p0, p1;
  logic [15:0] ext_pins = 16'h9c3a;
  wire [3:0] bus;
  int fail_count = 0;
  int total_checks = 0;
  always #2 clk = ~clk;
  // A bus nobody drives flips, so stale values cannot pass
  assign bus = h_oe ? h_out : d_oe[0] ? n0 : d_oe[1] ? n1 : ~last;
  always @(posedge clk) last <= bus;
  nbx_host #(.NUM_DEV(2)) u_nbx_host (.i_core_clk(clk), .i_reset(rst), .i_req_valid(req_valid), .i_req(req),
    .i_req_dev(req_dev), .o_req_ready(ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_rsp_stale(rsp_stale), .i_nib_in(bus), .o_nib_out(h_out), .o_nib_oe(h_oe), .o_strobe(strobe), .o_sel_n(sel_n));
  nbx_exp_model u_dev0 (.i_strobe(strobe), .i_sel_n(sel_n[0]), .i_nib(bus), .i_ext(ext_pins), .o_nib(n0),
    .o_nib_oe(d_oe[0]), .o_port(p0), .o_port_oe(poe0));
  nbx_exp_model u_dev1 (.i_strobe(strobe), .i_sel_n(sel_n[1]), .i_nib(bus), .i_ext(ext_pins), .o_nib(n1),
    .o_nib_oe(d_oe[1]), .o_port(p1), .o_port_oe(poe1));
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] seen);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // One whole transfer; any read answer is captured on the way
  task automatic xfer(input logic [1:0] op, input logic [1:0] port, input logic dev, input logic [3:0] d);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op: op, port: port, data: d};
    req_dev = dev;
    @(negedge clk);
    req_valid = 1'b0;
    got = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 1000) begin
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        rd = rsp_data;
        st = rsp_stale;
      end
      @(negedge clk);
      n++;
    end
    if (n >= 1000) begin
      fail_count++;
      end_of_test();
    end
  endtask
  task automatic chk_ports();
    for (int p = 0; p < 4; p++) begin
      chk("port latch", lat[p], p0[p*4+:4]);
    end
  endtask
  task automatic t_reset();
    chk("strobe idle", 4'h1, {3'h0, strobe});
    chk("bus drive", 4'h0, {3'h0, h_oe});
    chk("selects", 4'h3, {2'h0, sel_n});
    chk("ports float", 4'h0, poe0);
  endtask
  task automatic t_write();
    for (int p = 0; p < 4; p++) begin
      xfer(OP_WRITE, p[1:0], 1'b0, 4'(p + 5));
      lat[p] = 4'(p + 5);
    end
    chk_ports();
    chk("ports drive", 4'hf, poe0);
    chk("other device", 4'h0, poe1);
  endtask
  task automatic t_logic();
    xfer(OP_OR, 2'h1, 1'b0, 4'h8);
    lat[1] = lat[1] | 4'h8;
    xfer(OP_AND, 2'h2, 1'b0, 4'h3);
    lat[2] = lat[2] & 4'h3;
    xfer(OP_WRITE, 2'h0, 1'b0, 4'hc);
    lat[0] = 4'hc;
    chk_ports();
  endtask
  task automatic t_read();
    xfer(OP_READ, 2'h3, 1'b0, 4'h0);
    chk("read answer", 4'h1, {3'h0, got});
    chk("read data", ext_pins[15:12], rd);
    chk("first read stale", 4'h1, {3'h0, st});
    chk("read port floats", 4'h7, poe0);
    xfer(OP_READ, 2'h3, 1'b0, 4'h0);
    chk("second read stale", 4'h0, {3'h0, st});
    chk("bus released", 4'h0, {3'h0, h_oe});
    chk("device bus released", 4'h0, {3'h0, d_oe[0]});
  endtask
  task automatic t_dev1();
    xfer(OP_WRITE, 2'h0, 1'b1, 4'ha);
    chk("second device", 4'ha, p1[3:0]);
    chk("second drive", 4'h1, poe1);
    chk_ports();
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_write();
    t_logic();
    t_read();
    t_dev1();
    end_of_test();
  end
endmodule
